// ---- design/rirq_consts.svh ----
// register offsets, field positions, reset values and sizes of the irq block
`ifndef RIRQ_CONSTS_SVH
`define RIRQ_CONSTS_SVH

// device register offsets (index on the device register port)
`define RIRQ_ADDR_ROUTE       8'h0d
`define RIRQ_ADDR_CTRL        8'h0e
`define RIRQ_ADDR_LEVEL       8'h0f

// routing register fields
`define RIRQ_SEL0_HI          7
`define RIRQ_SEL0_LO          6
`define RIRQ_SEL1_HI          5
`define RIRQ_SEL1_LO          4
`define RIRQ_TXSEL_BIT        3
`define RIRQ_FULL_BIT         2
`define RIRQ_NEMPTY_BIT       1
`define RIRQ_OVR_BIT          0

// control register fields
`define RIRQ_METHOD_BIT       7
`define RIRQ_FILL_BIT         6
`define RIRQ_TXDONE_BIT       5
`define RIRQ_TXSTART_BIT      4
`define RIRQ_ALARM_EN_BIT     3
`define RIRQ_ALARM_BIT        2
`define RIRQ_LOCK_BIT         1
`define RIRQ_LOCK_EN_BIT      0

// reset values
`define RIRQ_SEL_RST          2'h0
`define RIRQ_LEVEL_RST        8'h00
`define RIRQ_LOCK_EN_RST      1'b1

// data mode codes
`define RIRQ_MODE_CONT        2'h0
`define RIRQ_MODE_BUF         2'h1

// fifo size in bytes
`define RIRQ_FIFO_DEPTH       64

// host command/status registers on apb
`define RIRQ_APB_CMD          12'h000
`define RIRQ_APB_STATUS       12'h004
`define RIRQ_CMD_GO_BIT       31
`define RIRQ_CMD_WR_BIT       16
`define RIRQ_STS_BUSY_BIT     0
`define RIRQ_STS_IRQ0_BIT     16
`define RIRQ_STS_IRQ1_BIT     17
`define RIRQ_STS_LOCK_BIT     18

`endif

// ---- design/rirq_pkg.sv ----
// types shared by both ends of the irq routing block
package rirq_pkg;

   // transceiver operating state
   typedef enum logic [1:0] {
      RIRQ_STBY,
      RIRQ_RX,
      RIRQ_TX,
      RIRQ_SLEEP
   } rirq_xcvr_type;

   // host command sequencer
   typedef enum logic [0:0] {
      RIRQ_IDLE,
      RIRQ_WAIT
   } rirq_hstate_type;

   // whole device-end state
   typedef struct packed {
      logic [1:0] sel0;
      logic [1:0] sel1;
      logic       tx_sel;
      logic       overrun;
      logic       fill_method;
      logic       fill_flag;
      logic       manual_fill;
      logic       tx_done;
      logic       tx_start_sel;
      logic       alarm_en;
      logic       alarm_flag;
      logic       lock_flag;
      logic       lock_en;
      logic [7:0] level;
      logic [7:0] rdata;
      logic       ack;
      logic       flush;
      logic       in_tx;
   } rirq_dev_type;

   // whole host-end state
   typedef struct packed {
      rirq_hstate_type st;
      logic            req;
      logic            wr;
      logic [7:0]      addr;
      logic [7:0]      wdata;
      logic [7:0]      rdata;
      logic [31:0]     prdata;
      logic            pslverr;
   } rirq_host_type;

endpackage : rirq_pkg

// ---- design/rirq_if.sv ----
// link between the irq block and its host: register port and irq pins
`timescale 1ns/100ps
interface rirq_if;
   logic       reg_req;     // one-cycle register access request
   logic       reg_wr;      // 1 write, 0 read
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic       reg_ack;     // one-cycle answer, the cycle after reg_req
   logic       irq0;
   logic       irq1;
   logic       lock_pin_o;  // lock pin drive value
   logic       lock_pin_oe; // high while the device drives the lock pin

   modport device (input reg_req, reg_wr, reg_addr, reg_wdata,
                   output reg_rdata, reg_ack, irq0, irq1, lock_pin_o, lock_pin_oe);
   modport host   (output reg_req, reg_wr, reg_addr, reg_wdata,
                   input reg_rdata, reg_ack, irq0, irq1, lock_pin_o, lock_pin_oe);
endinterface : rirq_if

// ---- design/rirq_device.sv ----
// device end: irq source routing, fifo flags, fill and tx start control
//
// Added by the designer: the APB slave port.
`timescale 1ns/100ps
// parameter defaults use these macros, so they must be known before the header
`include "rirq_consts.svh"

// Summary of operation
// R1: continuous rx/stby line0: sync, 01 gives alarm
// R2: buffered/packet rx/stby line0 selector mapping
// R3: continuous rx/stby line1 carries recovered bit clock
// R4: buffered/packet rx/stby line1 selector mapping
// R5: fifo level sources valid in standby too
// R6: tx line1: bit clock, fifo-full or done
// R7: read-only fifo-full status bit
// R8: read-only active-high fifo-not-empty bit
// R9: sticky overrun; write one clears and flushes
// R10: fill method bit: auto on sync or manual
// R11: auto fill flag; write one re-arms if no overrun
// R12: host starts and stops manual fill
// R13: manual fill: one starts, zero stops
// R14: tx-done set when last bit shifted out
// R15: buffered tx start: full or not empty
// R16: packet tx start: threshold or not empty
// R17: alarm enable bit resets zero, gates alarm
// R18: sticky alarm when strength exceeds level; w1c
// R19: lock status bit, write one clears
// R20: lock pin enable routes flag, else released
// R21: eight-bit alarm level compared to strength
// R22: irq lines follow selection with no latency
module rirq_device #(
   parameter int FIFO_DEPTH = `RIRQ_FIFO_DEPTH
) (
   input  wire logic                  clk_i,
   input  wire logic                  srst_i,
   rirq_if.device                     link,
   input  wire logic [1:0]            data_mode_i,
   input  wire rirq_pkg::rirq_xcvr_type xcvr_state_i,
   input  wire logic                  sync_det_i,
   input  wire logic                  write_byte_i,
   input  wire logic                  payload_ready_i,
   input  wire logic                  addr_filt_en_i,
   input  wire logic                  addr_match_i,
   input  wire logic                  crc_ok_i,
   input  wire logic                  recovered_bit_clock_i,
   input  wire logic                  shift_empty_i,
   input  wire logic [6:0]            fifo_count_i,
   input  wire logic                  fifo_overrun_i,
   input  wire logic [6:0]            queue_level_setting_i,
   input  wire logic [7:0]            signal_strength_i,
   input  wire logic                  pll_lock_i,
   output logic                       fifo_flush_o,
   output logic                       fill_enable_o,
   output logic                       tx_start_o
);
   import rirq_pkg::*;

   rirq_dev_type s_r;
   rirq_dev_type s_nxt;

   logic fifo_full;
   logic fifo_nempty;
   logic fifo_thr;
   logic alarm_src;
   logic rx_side;
   logic buf_mode;
   logic cont_mode;
   logic wr13;
   logic wr14;
   logic wr15;

   // fifo level flags, also meaningful in standby
   assign fifo_full   = (fifo_count_i >= 7'(FIFO_DEPTH));        // see R7 R5
   assign fifo_nempty = (fifo_count_i != 7'h00);                 // see R8 R5
   assign fifo_thr    = (fifo_count_i >= queue_level_setting_i); // see R16

   assign alarm_src = s_r.alarm_flag;
   assign rx_side   = (xcvr_state_i == RIRQ_RX) || (xcvr_state_i == RIRQ_STBY);
   assign buf_mode  = (data_mode_i == `RIRQ_MODE_BUF);
   assign cont_mode = (data_mode_i == `RIRQ_MODE_CONT);

   assign wr13 = link.reg_req && link.reg_wr && (link.reg_addr == `RIRQ_ADDR_ROUTE);
   assign wr14 = link.reg_req && link.reg_wr && (link.reg_addr == `RIRQ_ADDR_CTRL);
   assign wr15 = link.reg_req && link.reg_wr && (link.reg_addr == `RIRQ_ADDR_LEVEL);

   ////////////////////////////////////////////////////////////////////////////
   // irq line multiplexers, purely combinational so lines track selection
   always_comb begin
      link.irq0 = 1'b0;
      link.irq1 = 1'b0;
      if (rx_side) begin
         if (cont_mode) begin
            link.irq0 = (s_r.sel0 == 2'h1) ? alarm_src : sync_det_i;    // see R1 R22
            link.irq1 = recovered_bit_clock_i;                          // see R3
         end else begin
            unique case (s_r.sel0)                                      // see R2 R22
               2'h0: link.irq0 = buf_mode ? 1'b0 : payload_ready_i;
               2'h1: link.irq0 = write_byte_i;
               2'h2: link.irq0 = fifo_nempty;                           // see R5
               2'h3: link.irq0 = (!buf_mode && addr_filt_en_i) ? addr_match_i
                                                               : sync_det_i;
            endcase
            unique case (s_r.sel1)                                      // see R4 R22
               2'h0: link.irq1 = buf_mode ? 1'b0 : crc_ok_i;
               2'h1: link.irq1 = fifo_full;                             // see R5
               2'h2: link.irq1 = alarm_src;
               2'h3: link.irq1 = fifo_thr;
            endcase
         end
      end else if (xcvr_state_i == RIRQ_TX) begin
         if (cont_mode) begin
            link.irq1 = recovered_bit_clock_i;                          // see R6
         end else begin
            link.irq1 = s_r.tx_sel ? s_r.tx_done : fifo_full;           // see R6
            // tx line0: fifo threshold when not buffered and start choice zero, else not-empty
            link.irq0 = (!buf_mode && !s_r.tx_start_sel) ? fifo_thr     // see R16
                                                         : fifo_nempty; // see R15
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // next state: register writes, sticky flags (set beats clear), read data
   always_comb begin
      s_nxt       = s_r;
      s_nxt.ack   = link.reg_req;
      s_nxt.flush = 1'b0;
      s_nxt.in_tx = (xcvr_state_i == RIRQ_TX);

      if (wr13) begin
         s_nxt.sel0   = link.reg_wdata[`RIRQ_SEL0_HI:`RIRQ_SEL0_LO];
         s_nxt.sel1   = link.reg_wdata[`RIRQ_SEL1_HI:`RIRQ_SEL1_LO];
         s_nxt.tx_sel = link.reg_wdata[`RIRQ_TXSEL_BIT];
         if (link.reg_wdata[`RIRQ_OVR_BIT]) begin
            s_nxt.overrun = 1'b0;                                       // see R9
            s_nxt.flush   = 1'b1;                                       // see R9
         end
      end
      if (fifo_overrun_i) begin
         s_nxt.overrun = 1'b1;                                          // see R9
      end

      if (wr14) begin
         s_nxt.fill_method  = link.reg_wdata[`RIRQ_METHOD_BIT];         // see R10
         s_nxt.tx_start_sel = link.reg_wdata[`RIRQ_TXSTART_BIT];        // see R15 R16
         s_nxt.alarm_en     = link.reg_wdata[`RIRQ_ALARM_EN_BIT];       // see R17
         s_nxt.lock_en      = link.reg_wdata[`RIRQ_LOCK_EN_BIT];        // see R20
         if (link.reg_wdata[`RIRQ_METHOD_BIT]) begin
            s_nxt.manual_fill = link.reg_wdata[`RIRQ_FILL_BIT];         // see R13 R12
         end else if (link.reg_wdata[`RIRQ_FILL_BIT] && !s_r.overrun) begin
            s_nxt.fill_flag = 1'b0;                                     // see R11
         end
         if (link.reg_wdata[`RIRQ_ALARM_BIT]) begin
            s_nxt.alarm_flag = 1'b0;                                    // see R18
         end
         if (link.reg_wdata[`RIRQ_LOCK_BIT]) begin
            s_nxt.lock_flag = 1'b0;                                     // see R19
         end
      end
      // sets placed after clears so a same-cycle event is never lost
      if (buf_mode && !s_r.fill_method && sync_det_i && !s_r.overrun) begin
         s_nxt.fill_flag = 1'b1;                                        // see R11 R10
      end
      if (s_r.alarm_en && (signal_strength_i > s_r.level)) begin
         s_nxt.alarm_flag = 1'b1;                                       // see R18 R17 R21
      end
      if (pll_lock_i) begin
         s_nxt.lock_flag = 1'b1;                                        // see R19
      end

      // done flag rearms on entry into tx, set when shifter drains
      if (!s_r.in_tx && s_nxt.in_tx) begin
         s_nxt.tx_done = 1'b0;
      end
      if (s_r.in_tx && shift_empty_i && !fifo_nempty) begin
         s_nxt.tx_done = 1'b1;                                          // see R14
      end

      if (wr15) begin
         s_nxt.level = link.reg_wdata;                                  // see R21
      end

      // read data captured at the request, status seen the same cycle
      if (link.reg_req && !link.reg_wr) begin
         unique case (link.reg_addr)
            `RIRQ_ADDR_ROUTE: s_nxt.rdata = {s_r.sel0, s_r.sel1, s_r.tx_sel,
                                             fifo_full,                 // see R7
                                             fifo_nempty,               // see R8
                                             s_r.overrun};
            `RIRQ_ADDR_CTRL:  s_nxt.rdata = {s_r.fill_method,
                                             s_r.fill_method ? s_r.manual_fill
                                                             : s_r.fill_flag,
                                             s_r.tx_done, s_r.tx_start_sel,
                                             s_r.alarm_en, s_r.alarm_flag,
                                             s_r.lock_flag, s_r.lock_en};
            `RIRQ_ADDR_LEVEL: s_nxt.rdata = s_r.level;
            default:          s_nxt.rdata = 8'h00; // unmapped reads zero
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         s_r              <= '0;
         s_r.sel0         <= `RIRQ_SEL_RST;                             // see R1
         s_r.sel1         <= `RIRQ_SEL_RST;
         s_r.level        <= `RIRQ_LEVEL_RST;                           // see R21
         s_r.lock_en      <= `RIRQ_LOCK_EN_RST;                         // see R20
         s_r.alarm_en     <= 1'b0;                                      // see R17
      end else begin
         s_r <= s_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   assign link.reg_rdata  = s_r.rdata;
   assign link.reg_ack    = s_r.ack;
   assign link.lock_pin_o  = s_r.lock_flag;                             // see R20
   assign link.lock_pin_oe = s_r.lock_en;                               // see R20
   assign fifo_flush_o    = s_r.flush;

   // storing bytes: buffered mode follows method, other modes always store
   assign fill_enable_o = !buf_mode ? 1'b1 :
                          (s_r.fill_method ? s_r.manual_fill : s_r.fill_flag); // see R12 R13

   // transmit start condition
   always_comb begin
      tx_start_o = 1'b0;
      if (s_r.in_tx && !cont_mode) begin
         if (s_r.tx_start_sel) begin
            tx_start_o = fifo_nempty;                                   // see R15 R16
         end else begin
            tx_start_o = buf_mode ? fifo_full : fifo_thr;               // see R15 R16
         end
      end
   end

endmodule : rirq_device

// ---- design/rirq_host.sv ----
// host end: apb command/status registers driving the device register port
`timescale 1ns/100ps
module rirq_host (
   input  wire logic        clk_i,
   input  wire logic        srst_i,
   rirq_if.host             link,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr
);
   import rirq_pkg::*;

   `include "rirq_consts.svh"

   rirq_host_type h_r;
   rirq_host_type h_nxt;

   logic apb_go;
   logic busy;

   assign apb_go = psel && penable;
   assign busy   = (h_r.st == RIRQ_WAIT);

   ////////////////////////////////////////////////////////////////////////////
   // apb decode and command sequencer; a command written while busy is dropped
   always_comb begin
      h_nxt         = h_r;
      h_nxt.req     = 1'b0;
      h_nxt.pslverr = 1'b0;
      if (psel && !penable) begin
         // setup cycle: prepare read data so access completes at once
         unique case (paddr)
            `RIRQ_APB_CMD:    h_nxt.prdata = {16'h0000, h_r.wdata, h_r.addr};
            `RIRQ_APB_STATUS: h_nxt.prdata = {13'h0000, link.lock_pin_o && link.lock_pin_oe,
                                              link.irq1, link.irq0, h_r.rdata,
                                              7'h00, busy};
            default:          h_nxt.prdata = 32'h0000_0000;
         endcase
         h_nxt.pslverr = (paddr != `RIRQ_APB_CMD) && (paddr != `RIRQ_APB_STATUS);
      end else if (apb_go) begin
         h_nxt.pslverr = h_r.pslverr;
      end
      unique case (h_r.st)
         RIRQ_IDLE: begin
            if (apb_go && pwrite && (paddr == `RIRQ_APB_CMD) && pwdata[`RIRQ_CMD_GO_BIT]) begin
               h_nxt.addr  = pwdata[7:0];
               h_nxt.wdata = pwdata[15:8];
               h_nxt.wr    = pwdata[`RIRQ_CMD_WR_BIT];
               h_nxt.req   = 1'b1;
               h_nxt.st    = RIRQ_WAIT;
            end
         end
         RIRQ_WAIT: begin
            if (link.reg_ack) begin
               if (!h_r.wr) begin
                  h_nxt.rdata = link.reg_rdata;
               end
               h_nxt.st = RIRQ_IDLE;
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         h_r <= '0;
      end else begin
         h_r <= h_nxt;
      end
   end

   assign pready         = 1'b1; // every access finishes in one access cycle
   assign prdata         = h_r.prdata;
   assign pslverr        = h_r.pslverr && penable;
   assign link.reg_req   = h_r.req;
   assign link.reg_wr    = h_r.wr;
   assign link.reg_addr  = h_r.addr;
   assign link.reg_wdata = h_r.wdata;

endmodule : rirq_host

// ---- bench/rirq_checker.sv ----
// interface checker for the irq routing block link
`timescale 1ns/100ps
module rirq_checker (
   input wire logic       clk_i,
   input wire logic       srst_i,
   input wire logic       reg_req,
   input wire logic       reg_wr,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic       reg_ack,
   input wire logic       irq0,
   input wire logic       irq1,
   input wire logic       lock_pin_o,
   input wire logic       lock_pin_oe
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (srst_i);
   ////////////////////////////////////////////////////////////
   // register port handshake
   chk_ack_after_req: assert property (reg_req |=> reg_ack)
      else $error("no ack one cycle after a request");
   chk_ack_has_cause: assert property (reg_ack |-> $past(reg_req))
      else $error("ack without a request");
   chk_req_single: assert property (reg_req |=> !reg_req)
      else $error("request longer than one cycle");
   // read data only moves when a read is answered
   chk_rdata_hold: assert property ($changed(reg_rdata) |-> reg_ack && !reg_wr)
      else $error("read data moved without a read");
   chk_unmapped_zero: assert property (reg_ack && !reg_wr
      && !(reg_addr inside {8'h0d, 8'h0e, 8'h0f}) |-> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   ////////////////////////////////////////////////////////////
   // status bits and lock pin
   chk_full_nempty: assert property (
      reg_ack && !reg_wr && reg_addr == 8'h0d && reg_rdata[2] |-> reg_rdata[1])
      else $error("full reported with empty queue");
   chk_reset_state: assert property ($fell(srst_i) |-> lock_pin_oe && !reg_ack)
      else $error("wrong state after reset");
   chk_lock_en_wr: assert property (
      reg_req && reg_wr && reg_addr == 8'h0e |-> ##2 lock_pin_oe == reg_wdata[0])
      else $error("lock pin enable does not follow write");
   chk_lock_oe_read: assert property (
      reg_ack && !reg_wr && reg_addr == 8'h0e |-> reg_rdata[0] == lock_pin_oe)
      else $error("lock enable bit and pin enable differ");
   chk_lock_bit_pin: assert property (
      reg_ack && !reg_wr && reg_addr == 8'h0e |-> reg_rdata[1] == $past(lock_pin_o))
      else $error("lock status bit and lock pin differ");
endmodule : rirq_checker

// ---- bench/tb_top.sv ----
// self-checking bench: host and device ends joined by the link
`timescale 1ns/100ps
module tb_top;
   import rirq_pkg::*;
   logic          clk_i = 1'b0;
   logic          srst_i = 1'b1;
   logic          psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0]   paddr = 12'h000;
   logic [31:0]   pwdata = 32'h0, prdata, s;
   logic          pready, pslverr, e;
   logic [1:0]    mode = 2'h0;
   rirq_xcvr_type st = RIRQ_RX;
   logic          sync = 1'b0, wbyte = 1'b0, pay = 1'b0, afen = 1'b0, amatch = 1'b0;
   logic          crc = 1'b0, bclk = 1'b0, sh_empty = 1'b0, ovr = 1'b0, lock = 1'b0;
   logic [6:0]    cnt = 7'h00, qlev = 7'h0a;
   logic [7:0]    rssi = 8'h00, r;
   logic          flush, fill_en, tx_go;
   logic [2:0]    mk, xp;
   logic [7:0]    pat [4] = '{8'h5b, 8'h5a, 8'h3c, 8'hc3};
   int            cs [4] = '{5, 64, 64, 5};
   int            error_cnt = 0, n_checks = 0, cyc = 0, flush_cnt = 0;

   rirq_if i_rirq_if ();
   rirq_device #(.FIFO_DEPTH(64)) i_rirq_device (.clk_i(clk_i), .srst_i(srst_i),
      .link(i_rirq_if), .data_mode_i(mode), .xcvr_state_i(st), .sync_det_i(sync),
      .write_byte_i(wbyte), .payload_ready_i(pay), .addr_filt_en_i(afen),
      .addr_match_i(amatch), .crc_ok_i(crc), .recovered_bit_clock_i(bclk),
      .shift_empty_i(sh_empty), .fifo_count_i(cnt), .fifo_overrun_i(ovr),
      .queue_level_setting_i(qlev), .signal_strength_i(rssi), .pll_lock_i(lock),
      .fifo_flush_o(flush), .fill_enable_o(fill_en), .tx_start_o(tx_go));
   rirq_host i_rirq_host (.clk_i(clk_i), .srst_i(srst_i), .link(i_rirq_if),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
   rirq_checker i_rirq_checker (.clk_i(clk_i), .srst_i(srst_i),
      .reg_req(i_rirq_if.reg_req), .reg_wr(i_rirq_if.reg_wr),
      .reg_addr(i_rirq_if.reg_addr), .reg_wdata(i_rirq_if.reg_wdata),
      .reg_rdata(i_rirq_if.reg_rdata), .reg_ack(i_rirq_if.reg_ack),
      .irq0(i_rirq_if.irq0), .irq1(i_rirq_if.irq1),
      .lock_pin_o(i_rirq_if.lock_pin_o), .lock_pin_oe(i_rirq_if.lock_pin_oe));

   ////////////////////////////////////////////////////////////
   // clock, flush pulse counter and hang guard
   always #4 clk_i = ~clk_i;
   always @(negedge clk_i) if (flush === 1'b1) flush_cnt++;
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         $display("Error %0t: timeout", $time);
         end_sim();
      end
   end

   ////////////////////////////////////////////////////////////
   // compare and verdict
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_sim

   // one apb transfer; data taken at the edge that samples pready high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
      @(posedge clk_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      do @(posedge clk_i); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // device register access; two polls at least, busy may rise late
   task automatic dev(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] rd);
      logic [31:0] v;
      logic        x;
      int          n;
      apb(1'b1, 12'h000, {1'b1, 14'h0, w, d, a}, v, x);
      n = 0;
      do begin
         apb(1'b0, 12'h004, 32'h0, v, x);
         n++;
      end while ((v[0] !== 1'b0 || n < 2) && n < 50);
      rd = v[15:8];
   endtask : dev

   // expected {tx start, line1, line0}; t set means transmit state
   function automatic logic [2:0] ex(int m, int sl, int t, logic [7:0] v, int c);
      logic ne, fu, th, i0, i1, ts;
      ne = c != 0;
      fu = c >= 64;
      th = c >= 10;
      ts = 1'b0;
      if (t != 0) begin
         i1 = (m == 0) ? v[6] : (sl[0] ? 1'b0 : fu);
         i0 = (m == 2 && !sl[1]) ? th : ne;
         ts = (m == 0) ? 1'b0 : sl[1] ? ne : (m == 1) ? fu : th;
      end else if (m == 0) begin
         i0 = (sl == 1) ? 1'b0 : v[0];
         i1 = v[6];
      end else begin
         case (sl)
            0: i0 = (m == 2) & v[2];
            1: i0 = v[1];
            2: i0 = ne;
            default: i0 = ((m == 2) & v[3]) ? v[4] : v[0];
         endcase
         case (sl)
            0: i1 = (m == 2) & v[5];
            1: i1 = fu;
            2: i1 = 1'b0;
            default: i1 = th;
         endcase
      end
      return {ts, i1, i0};
   endfunction : ex

   ////////////////////////////////////////////////////////////
   // test sequence
   initial begin
      repeat (16) @(posedge clk_i);
      srst_i <= 1'b0;
      dev(1'b0, 8'h0d, 8'h00, r); chk(r, 8'h00);
      dev(1'b0, 8'h0e, 8'h00, r); chk(r, 8'h01);
      dev(1'b0, 8'h0f, 8'h00, r); chk(r, 8'h00);
      dev(1'b0, 8'h10, 8'h00, r); chk(r, 8'h00);
      apb(1'b0, 12'h008, 32'h0, s, e); chk(e, 1'b1);
      $display("test reset done");
      // every mode and selector in rx, standby and tx against the source table
      for (int m = 0; m < 3; m++) begin
         for (int sl = 0; sl < 4; sl++) begin
            dev(1'b1, 8'h0d, {sl[1:0], sl[1:0], sl[0], 3'b000}, r);
            dev(1'b1, 8'h0e, {3'b000, sl[1], 4'b0001}, r);
            for (int k = 0; k < 4; k++) begin
               @(posedge clk_i);
               mode <= m[1:0];
               st <= k[0] ? RIRQ_TX : (k == 0) ? RIRQ_RX : RIRQ_STBY;
               {bclk, crc, amatch, afen, pay, wbyte, sync} <= pat[k][6:0];
               cnt <= 7'(cs[k]);
               @(negedge clk_i);
               mk = (m == 0 && k[0]) ? 3'b110 : 3'b111;
               xp = ex(m, sl, k % 2, pat[k], cs[k]) & mk;
               chk({i_rirq_if.irq1, i_rirq_if.irq0} & mk[1:0],
                   xp[1:0]);
               // tx start follows the registered state, one cycle later
               @(negedge clk_i);
               chk({tx_go, i_rirq_if.irq1, i_rirq_if.irq0} & mk, xp);
            end
         end
      end
      $display("test routing done");
      @(posedge clk_i);
      {mode, sync, cnt, rssi} <= {2'h0, 1'b0, 7'h00, 8'h50};
      st <= RIRQ_RX;
      dev(1'b1, 8'h0f, 8'h40, r);
      dev(1'b0, 8'h0e, 8'h00, r); chk(r[2], 1'b0);
      dev(1'b1, 8'h0e, 8'h09, r);
      dev(1'b0, 8'h0e, 8'h00, r); chk(r, 8'h4d);
      dev(1'b1, 8'h0d, 8'h40, r);
      @(negedge clk_i); chk(i_rirq_if.irq0, 1'b1);
      @(posedge clk_i) rssi <= 8'h40;
      dev(1'b1, 8'h0e, 8'h0d, r);
      dev(1'b0, 8'h0e, 8'h00, r); chk(r, 8'h49);
      dev(1'b0, 8'h0f, 8'h00, r); chk(r, 8'h40);
      $display("test alarm done");
      @(posedge clk_i) lock <= 1'b1;
      dev(1'b0, 8'h0e, 8'h00, r); chk(r[1:0], 2'h3);
      @(negedge clk_i); chk({i_rirq_if.lock_pin_oe, i_rirq_if.lock_pin_o}, 2'h3);
      @(posedge clk_i) lock <= 1'b0;
      dev(1'b1, 8'h0e, 8'h02, r);
      dev(1'b0, 8'h0e, 8'h00, r); chk(r[1:0], 2'h0);
      @(negedge clk_i); chk(i_rirq_if.lock_pin_oe, 1'b0);
      $display("test lock done");
      @(posedge clk_i);
      {mode, cnt, ovr} <= {2'h1, 7'd64, 1'b1};
      @(posedge clk_i) ovr <= 1'b0;
      dev(1'b0, 8'h0d, 8'h00, r); chk(r[2:0], 3'h7);
      flush_cnt = 0;
      dev(1'b1, 8'h0d, 8'h01, r);
      dev(1'b0, 8'h0d, 8'h00, r); chk(r[2:0], 3'h6);
      chk(flush_cnt, 1);
      @(posedge clk_i) cnt <= 7'h00;
      dev(1'b0, 8'h0d, 8'h00, r); chk(r[2:0], 3'h0);
      $display("test overrun done");
      dev(1'b1, 8'h0e, 8'h40, r);
      dev(1'b0, 8'h0e, 8'h00, r); chk(r[6], 1'b0);
      @(posedge clk_i) sync <= 1'b1;
      @(posedge clk_i) sync <= 1'b0;
      dev(1'b0, 8'h0e, 8'h00, r); chk(r[6], 1'b1);
      dev(1'b1, 8'h0e, 8'hc0, r);
      @(negedge clk_i); chk(fill_en, 1'b1);
      dev(1'b1, 8'h0e, 8'h80, r);
      @(negedge clk_i); chk(fill_en, 1'b0);
      $display("test fill done");
      @(posedge clk_i);
      st <= RIRQ_TX;
      sh_empty <= 1'b1;
      dev(1'b1, 8'h0d, 8'h08, r);
      dev(1'b0, 8'h0e, 8'h00, r); chk(r[5], 1'b1);
      @(negedge clk_i); chk(i_rirq_if.irq1, 1'b1);
      $display("test tx done");
      end_sim();
   end
endmodule : tb_top
